// ===== spm_asserts.sv
`timescale 1ns/1ps
module spm_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic irq
);
  logic [7:0] ctrl_r;
  logic [1:0] ien_r;
  logic take;
  assign take = avs_write && !avs_waitrequest && avs_byteenable[0];
  // shadow of the control and enable registers seen on the bus
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= 8'h00;
      ien_r <= 2'h0;
    end else if (take) begin
      if (avs_address == 10'h2f0) ctrl_r <= avs_writedata[7:0];
      if (avs_address == 10'h300) ien_r <= avs_writedata[1:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_half3;
    $stable(sck_out)[*7];
  endsequence
  property p_answer;
    s_req |=> !avs_waitrequest;
  endproperty
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_rd_hi;
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  property p_oe_on;
    (ctrl_r[7:6] == 2'b11 && $stable(ctrl_r))[*2]
      |-> sck_oe && mosi_oe && !miso_oe;
  endproperty
  property p_oe_off;
    (!ctrl_r[7])[*2] |-> !sck_oe && !mosi_oe && !miso_oe;
  endproperty
  property p_idle;
    (sck_oe && $stable(ctrl_r) && $stable(sck_out))[*8]
      |-> sck_out == ctrl_r[5];
  endproperty
  property p_rate;
    (sck_oe && ctrl_r[1:0] == 2'b11 && $changed(sck_out)) |=> s_half3;
  endproperty
  property p_irq_en;
    (ien_r != 2'b11)[*2] |-> !irq;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_wait_one: assert property (p_wait_one) else $error("wait low");
  a_rd_hi: assert property (p_rd_hi) else $error("upper bits");
  a_oe_on: assert property (p_oe_on) else $error("pins off");
  a_oe_off: assert property (p_oe_off) else $error("pins on");
  a_idle: assert property (p_idle) else $error("idle level");
  a_rate: assert property (p_rate) else $error("half period");
  a_irq_en: assert property (p_irq_en) else $error("irq on");
endmodule : spm_asserts
bind spm_spi_port spm_asserts i_spm_asserts (.*);

// ===== spm_far_end.sv
`timescale 1ns/1ps
module spm_far_end (
  input wire logic sck,
  input wire logic mosi,
  input wire logic clock_idle_level,
  input wire logic sample_edge_select,
  input wire logic bit_order_select,
  input wire logic load,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  int e = 16;
  int o;
  int k;
  initial miso = 1'b0;
  initial rx = 8'h00;
  function automatic logic pick(input int i);
    return bit_order_select ? tx[i] : tx[7 - i];
  endfunction : pick
  always @(posedge load) begin
    e = 0;
    k = 0;
    o = sample_edge_select ? 0 : 1;
    miso = sample_edge_select ? ~miso : pick(0);
  end
  // edges count only inside a frame; leading edge leaves idle level
  always @(sck) begin
    if (e < 16) begin
      e++;
      if ((sck != clock_idle_level) ^ sample_edge_select) begin
        rx[bit_order_select ? k : 7 - k] = mosi;
        k++;
        if (e == 16) miso = ~miso;
      end else begin
        miso = o < 8 ? pick(o) : ~miso;
        o++;
      end
    end
  end
endmodule : spm_far_end

// ===== spm_pkg.sv
package spm_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'hbc;
  localparam logic [7:0] IDX_STAT = 8'hbd;
  localparam logic [7:0] IDX_DATA = 8'hbe;
  localparam logic [7:0] IDX_IEN = 8'hc0;
  localparam logic [7:0] IDX_ISTAT = 8'hc1;
  localparam logic [7:0] IDX_IMASK = 8'hc2;

  // serial_control_register fields
  localparam int CTRL_EN = 7;
  localparam int CTRL_ROLE = 6;
  localparam int CTRL_CLOCK_IDLE_LEVEL = 5;
  localparam int CTRL_SAMPLE_EDGE_SELECT = 4;
  localparam int CTRL_BIT_ORDER_SELECT = 2;
  localparam int CTRL_RATE = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // serial_status_register fields
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_OVF = 4;
  localparam int STAT_RBF = 3;
  localparam int STAT_BUSY = 2;

  localparam logic [7:0] DATA_RST = 8'h00;

  // interrupt enable register fields
  localparam int IEN_SPI = 0;
  localparam int IEN_GLOBAL = 1;
  localparam logic [1:0] IEN_RST = 2'h0;

  // sticky event status and mask layout
  localparam int EV_DONE = 0;
  localparam int EV_WRITE_COLLISION_FLAG = 1;
  localparam int EV_OVF = 2;
  localparam logic [2:0] EV_RST = 3'h0;

  // clock edges in one byte transfer
  localparam logic [4:0] XFER_EDGES = 5'h10;

  typedef enum logic [1:0] {
    SPM_IDLE = 2'b01,
    SPM_RUN = 2'b10
  } spm_state_e;
endpackage : spm_pkg

// ===== spm_spi_port.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Functional notes
// - enable bit switches port and hands pins over
// - role bit: 0 slave, 1 master; resets slave
// - polarity bit sets serial clock idle level
// - phase bit: sample first or second edge
// - order bit: msb first or lsb first
// - master rate field divides clock 2/4/8/16
// - done flag set at end, cleared ack/write0
// - collision on busy write, cleared idle write
// - overrun when end meets full; read/write0 clear
// - busy flag reads one during transfer
// - idle data write loads transmit buffer, and as master the shift register
// - one data address: write sends, read receives
// - done interrupts only with both enables set
module spm_spi_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic irq_ack,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in,
  output logic irq
);
  logic wait_r, done_r, write_collision_flag_r, ovf_r, rbf_r, irq_r;
  logic [31:0] rdata_r;
  logic [7:0] ctrl_r, tx_buf_r, rx_buf_r, tx_sh_r, rx_sh_r;
  logic [1:0] ien_r;
  logic [2:0] ev_r, mask_r;
  spm_pkg::spm_state_e st_r;
  logic [3:0] div_r;
  logic [4:0] edge_r;
  logic sck_r, out_r, sck_oe_r, mosi_oe_r, miso_oe_r;
  logic [2:0] sck_s, ss_s;
  logic [1:0] mosi_s, miso_s;

  logic req, acc_wr, acc_rd, rd_data;
  logic wr_ctrl, wr_stat, wr_data, wr_ien, wr_ev, wr_mask;
  logic [7:0] wbyte, tx_src;
  logic [31:0] rd_mux;
  logic en, master, clock_idle_level, sample_edge_select, bit_order_select, busy;
  logic [3:0] half_m1;
  logic m_tick, lead_ev, trail_ev, last_ev;
  logic start_m, start_s, start, abort, launch, sample, finish, rx_bit;

  assign en = ctrl_r[spm_pkg::CTRL_EN];
  assign master = ctrl_r[spm_pkg::CTRL_ROLE];
  assign clock_idle_level = ctrl_r[spm_pkg::CTRL_CLOCK_IDLE_LEVEL];
  assign sample_edge_select = ctrl_r[spm_pkg::CTRL_SAMPLE_EDGE_SELECT];
  assign bit_order_select = ctrl_r[spm_pkg::CTRL_BIT_ORDER_SELECT];
  assign busy = (st_r == spm_pkg::SPM_RUN);
  assign wbyte = avs_writedata[7:0];

  // avalon slave: one wait cycle, then the request is taken
  assign req = avs_read | avs_write;
  assign acc_wr = avs_write & ~wait_r & avs_byteenable[0];
  assign acc_rd = avs_read & ~wait_r;

  always_comb begin
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_data = 1'b0;
    wr_ien = 1'b0;
    wr_ev = 1'b0;
    wr_mask = 1'b0;
    rd_data = 1'b0;
    rd_mux = 32'h0;
    if (avs_address == {spm_pkg::IDX_CTRL, 2'b00}) begin
      wr_ctrl = acc_wr;
      rd_mux = {24'h0, ctrl_r};
    end else if (avs_address == {spm_pkg::IDX_STAT, 2'b00}) begin
      wr_stat = acc_wr;
      rd_mux = {24'h0, done_r, write_collision_flag_r, 1'b0, ovf_r, rbf_r, busy, 2'b00};
    end else if (avs_address == {spm_pkg::IDX_DATA, 2'b00}) begin
      wr_data = acc_wr;
      rd_data = acc_rd;
      rd_mux = {24'h0, rx_buf_r};
    end else if (avs_address == {spm_pkg::IDX_IEN, 2'b00}) begin
      wr_ien = acc_wr;
      rd_mux = {30'h0, ien_r};
    end else if (avs_address == {spm_pkg::IDX_ISTAT, 2'b00}) begin
      wr_ev = acc_wr;
      rd_mux = {29'h0, ev_r};
    end else if (avs_address == {spm_pkg::IDX_IMASK, 2'b00}) begin
      wr_mask = acc_wr;
      rd_mux = {29'h0, mask_r};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if (req & wait_r) begin
      wait_r <= 1'b0;
      rdata_r <= rd_mux;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= spm_pkg::CTRL_RST;
      ien_r <= spm_pkg::IEN_RST;
      mask_r <= spm_pkg::EV_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wbyte & 8'hf7;
      end
      if (wr_ien) begin
        ien_r <= wbyte[1:0];
      end
      if (wr_mask) begin
        mask_r <= wbyte[2:0];
      end
    end
  end

  // input synchronisers
  always_ff @(posedge clock) begin
    if (rst) begin
      sck_s <= 3'h0;
      mosi_s <= 2'h0;
      miso_s <= 2'h0;
      ss_s <= 3'h7;
    end else begin
      sck_s <= {sck_s[1:0], sck_in};
      mosi_s <= {mosi_s[0], mosi_in};
      miso_s <= {miso_s[0], miso_in};
      ss_s <= {ss_s[1:0], ss_n_in};
    end
  end

  always_comb begin
    case (ctrl_r[spm_pkg::CTRL_RATE +: 2])
      2'b00: half_m1 = 4'h0;
      2'b01: half_m1 = 4'h1;
      2'b10: half_m1 = 4'h3;
      default: half_m1 = 4'h7;
    endcase
  end

  assign m_tick = busy & master & (div_r == half_m1);
  always_comb begin
    lead_ev = 1'b0;
    trail_ev = 1'b0;
    if (master) begin
      lead_ev = m_tick & ~edge_r[0];
      trail_ev = m_tick & edge_r[0];
    end else if (busy & ~ss_s[2] & (sck_s[2] != sck_s[1])) begin
      lead_ev = (sck_s[1] != clock_idle_level);
      trail_ev = (sck_s[1] == clock_idle_level);
    end
  end

  assign start_m = en & master & wr_data & ~busy;
  assign start_s = en & ~master & ~busy & ss_s[2] & ~ss_s[1];
  assign start = start_m | start_s;
  assign abort = busy & (~en | (~master & ss_s[1]));
  assign last_ev = (edge_r == spm_pkg::XFER_EDGES - 5'h1);
  assign launch = sample_edge_select ? lead_ev : (trail_ev & ~last_ev);
  assign sample = sample_edge_select ? trail_ev : lead_ev;
  assign finish = busy & (lead_ev | trail_ev) & last_ev;
  assign rx_bit = master ? miso_s[1] : mosi_s[1];
  // a master start takes the byte being written, not the stale buffer
  assign tx_src = start_m ? wbyte : tx_buf_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= spm_pkg::SPM_IDLE;
      div_r <= 4'h0;
      edge_r <= 5'h0;
    end else begin
      case (st_r)
        spm_pkg::SPM_IDLE: begin
          div_r <= 4'h0;
          edge_r <= 5'h0;
          if (start) begin
            st_r <= spm_pkg::SPM_RUN;
          end
        end
        spm_pkg::SPM_RUN: begin
          div_r <= m_tick ? 4'h0 : div_r + 4'h1;
          if (lead_ev | trail_ev) begin
            edge_r <= edge_r + 5'h1;
          end
          if (finish | abort) begin
            st_r <= spm_pkg::SPM_IDLE;
          end
        end
        default: st_r <= spm_pkg::SPM_IDLE;
      endcase
    end
  end

  // shift path: both data outputs carry the launched bit
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_sh_r <= 8'h0;
      rx_sh_r <= 8'h0;
      out_r <= 1'b0;
      sck_r <= 1'b0;
    end else begin
      if (start) begin
        out_r <= bit_order_select ? tx_src[0] : tx_src[7];
        tx_sh_r <= bit_order_select ? {1'b0, tx_src[7:1]} : {tx_src[6:0], 1'b0};
        if (sample_edge_select) begin
          out_r <= out_r;
          tx_sh_r <= tx_src;
        end
      end else if (launch) begin
        out_r <= bit_order_select ? tx_sh_r[0] : tx_sh_r[7];
        tx_sh_r <= bit_order_select ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
      end
      if (sample) begin
        rx_sh_r <= bit_order_select ? {rx_bit, rx_sh_r[7:1]} : {rx_sh_r[6:0], rx_bit};
      end
      if (~busy | ~master) begin
        sck_r <= clock_idle_level;
      end else if (m_tick) begin
        sck_r <= ~sck_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sck_oe_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= en & master;
      mosi_oe_r <= en & master;
      miso_oe_r <= en & ~master & ~ss_s[1];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_buf_r <= spm_pkg::DATA_RST;
      rx_buf_r <= spm_pkg::DATA_RST;
    end else begin
      if (wr_data & ~busy) begin
        tx_buf_r <= wbyte;
      end
      if (finish) begin
        rx_buf_r <= sample
          ? (bit_order_select ? {rx_bit, rx_sh_r[7:1]} : {rx_sh_r[6:0], rx_bit})
          : rx_sh_r;
      end
    end
  end

  // flags: a hardware set wins over any clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      ovf_r <= 1'b0;
      rbf_r <= 1'b0;
    end else begin
      if (finish) begin
        done_r <= 1'b1;
      end else if (irq_ack | (wr_stat & ~wbyte[spm_pkg::STAT_DONE])) begin
        done_r <= 1'b0;
      end
      if (wr_data & busy) begin
        write_collision_flag_r <= 1'b1;
      end else if (wr_data | (wr_stat & ~wbyte[spm_pkg::STAT_WRITE_COLLISION_FLAG])) begin
        write_collision_flag_r <= 1'b0;
      end
      if (finish & rbf_r) begin
        ovf_r <= 1'b1;
      end else if (rd_data | (wr_stat & ~wbyte[spm_pkg::STAT_OVF])) begin
        ovf_r <= 1'b0;
      end
      if (finish) begin
        rbf_r <= 1'b1;
      end else if (rd_data | (wr_stat & ~wbyte[spm_pkg::STAT_RBF])) begin
        rbf_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ev_r <= spm_pkg::EV_RST;
      irq_r <= 1'b0;
    end else begin
      ev_r[spm_pkg::EV_DONE] <= finish |
        (ev_r[spm_pkg::EV_DONE] & ~(wr_ev & wbyte[spm_pkg::EV_DONE]));
      ev_r[spm_pkg::EV_WRITE_COLLISION_FLAG] <= (wr_data & busy) |
        (ev_r[spm_pkg::EV_WRITE_COLLISION_FLAG] & ~(wr_ev & wbyte[spm_pkg::EV_WRITE_COLLISION_FLAG]));
      ev_r[spm_pkg::EV_OVF] <= (finish & rbf_r) |
        (ev_r[spm_pkg::EV_OVF] & ~(wr_ev & wbyte[spm_pkg::EV_OVF]));
      irq_r <= ien_r[spm_pkg::IEN_GLOBAL] & ien_r[spm_pkg::IEN_SPI] &
        (|(ev_r & mask_r));
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign sck_out = sck_r;
  assign sck_oe = sck_oe_r;
  assign mosi_out = out_r;
  assign mosi_oe = mosi_oe_r;
  assign miso_out = out_r;
  assign miso_oe = miso_oe_r;
  assign irq = irq_r;
endmodule : spm_spi_port

// ===== spm_spi_port_tb.sv
`timescale 1ns/1ps
module spm_spi_port_tb;
  logic clock = 0;
  logic rst = 1;
  logic [9:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0] avs_byteenable = 4'hf;
  logic irq_ack = 0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sck_out, mosi_out, miso_in, irq;
  logic clock_idle_level = 0, sample_edge_select = 0, bit_order_select = 0, load = 0;
  logic [7:0] ftx = 0, frx, q, c, d, v;
  logic [2:0] mb;
  logic [1:0] rt;
  logic [7:0] r;
  logic s_sck = 0, s_mosi = 0, s_ss_n = 1, s_miso, s_moe;
  logic [7:0] sent[$];
  integer seed = 32'ha9dd8e3a;
  int failures = 0, samples_checked = 0;
  int done = 0, write_collision_flag = 0, ovf = 0, rbf = 0, ev = 0, n, h;
  spm_spi_port i_spm_spi_port (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_ack(irq_ack),
    .sck_in(s_sck), .sck_out(sck_out), .sck_oe(), .mosi_in(s_mosi),
    .mosi_out(mosi_out), .mosi_oe(), .miso_in(miso_in),
    .miso_out(s_miso), .miso_oe(s_moe), .ss_n_in(s_ss_n), .irq(irq));
  spm_far_end i_spm_far_end (.sck(sck_out), .mosi(mosi_out), .clock_idle_level(clock_idle_level),
    .sample_edge_select(sample_edge_select), .bit_order_select(bit_order_select), .load(load), .tx(ftx), .miso(miso_in),
    .rx(frx));
  initial forever #4 clock = ~clock;
  task final_report;
    $display("checks %0d errors %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task tmo;
    failures++;
    final_report();
  endtask : tmo
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function logic [7:0] st(input int b);
    return 8'(done * 128 + write_collision_flag * 64 + ovf * 16 + rbf * 8 + b * 4);
  endfunction : st
  task bus(input logic w, input logic [9:0] a, input logic [7:0] x);
    avs_address <= a;
    avs_writedata <= {24'h0, x};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) tmo();
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task wchg;
    h = 0;
    v = sck_out;
    while (sck_out === v && h < 40) begin
      @(posedge clock);
      h++;
    end
    if (h >= 40) tmo();
  endtask : wchg
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(1, 10'h2fc, 8'hff);
    for (int i = 0; i < 4; i++) begin
      bus(0, 10'h2f0 + 10'(i * 4), 0);
      chk(q, 8'h00);
    end
    bus(1, 10'h300, 8'h03);
    bus(1, 10'h308, 8'h01);
    for (int m = 0; m < 8; m++) begin
      mb = 3'(m);
      {clock_idle_level, sample_edge_select, bit_order_select} <= mb;
      ftx <= 8'($random(seed));
      // rate varies apart from phase so both phases receive at slow rates
      rt = mb[1:0] ^ {mb[2], 1'b0};
      c = {2'b11, mb[2:1], 1'b0, mb[0], rt};
      bus(1, 10'h2f0, c);
      repeat (2) @(posedge clock);
      load <= 1'b1;
      @(posedge clock);
      load <= 1'b0;
      d = 8'($random(seed));
      sent.push_back(d);
      bus(1, 10'h2f8, d);
      write_collision_flag = 0;
      wchg();
      wchg();
      chk(8'(h), 8'h01 << rt);
      if (m == 3) begin
        bus(1, 10'h2f8, 8'h5a);
        write_collision_flag = 1;
        ev |= 2;
        bus(0, 10'h2f4, 0);
        chk(q, st(1));
      end
      h = 0;
      do begin
        bus(0, 10'h2f4, 0);
        h++;
      end while (q[2] !== 1'b0 && h < 60);
      if (h >= 60) tmo();
      ev |= rbf ? 5 : 1;
      ovf |= rbf;
      rbf = 1;
      done = 1;
      chk(q, st(0));
      chk({7'h0, irq}, 8'h01);
      chk(frx, sent.pop_front());
      if (m[0]) begin
        bus(0, 10'h2f8, 0);
        if (rt[1]) chk(q, ftx);
        rbf = 0;
        ovf = 0;
        irq_ack <= 1'b1;
        @(posedge clock);
        irq_ack <= 1'b0;
        @(posedge clock);
      end else bus(1, 10'h2f4, 8'h7f);
      done = 0;
      bus(0, 10'h2f4, 0);
      chk(q, st(0));
      if (m > 4) begin
        bus(1, m == 6 ? 10'h308 : 10'h300, m == 7 ? 8'h02 : 8'h00);
        @(posedge clock);
        chk({7'h0, irq}, 8'h00);
        bus(1, m == 6 ? 10'h308 : 10'h300, m == 6 ? 8'h01 : 8'h03);
      end
      bus(0, 10'h304, 0);
      chk(q, 8'(ev));
      bus(1, 10'h304, 8'h07);
      ev = 0;
      @(posedge clock);
      chk({7'h0, irq}, 8'h00);
    end
    // slave role: the bench selects and clocks the port itself
    bus(1, 10'h2f0, 8'h80);
    d = 8'($random(seed));
    ftx <= 8'($random(seed));
    bus(1, 10'h2f8, d);
    s_ss_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk({7'h0, s_moe}, 8'h01);
    for (int i = 7; i >= 0; i--) begin
      s_mosi <= ftx[i];
      repeat (6) @(posedge clock);
      r[i] = s_miso;
      s_sck <= 1'b1;
      repeat (6) @(posedge clock);
      s_sck <= 1'b0;
    end
    repeat (6) @(posedge clock);
    s_ss_n <= 1'b1;
    repeat (6) @(posedge clock);
    done = 1;
    rbf = 1;
    bus(0, 10'h2f4, 0);
    chk(q, st(0));
    bus(0, 10'h2f8, 0);
    chk(q, ftx);
    chk(r, d);
    bus(1, 10'h2f0, 8'h00);
    repeat (4) @(posedge clock);
    final_report();
  end
endmodule : spm_spi_port_tb
